// ===== inc/asr_pkg.sv
`default_nettype none
package asr_pkg;
  // Register addresses (one byte register per address)
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_FOURTH_CONFIG_REGISTER = 4'h8;
  localparam logic [3:0] ADDR_MAP_CRC = 4'hF;

  // Status field positions
  localparam int STAT_SPI_ERR = 4;
  localparam int STAT_REG_ERR = 3;
  localparam int STAT_ADC_ERR = 2;
  localparam int STAT_SAT = 1;
  localparam int STAT_NEW = 0;

  // Command register fields
  localparam int CMD_START = 1;
  localparam int CMD_STOP = 0;
  localparam logic [5:0] RESET_CODE = 6'h16;
  localparam logic [1:0] RESET_TAIL = 2'h0;
  localparam logic [5:0] RESET_READ = 6'h00;

  // Fourth configuration register fields
  localparam int CFG4_FRAME_CHK = 2;
  localparam int CFG4_MAP_CHK = 1;

  // Reset values
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  localparam logic [7:0] CFG4_RESET_VAL = 8'h00;
  localparam logic [7:0] MAP_CRC_RESET_VAL = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Default conversion length in system clocks
  localparam int CONV_CYCLES_DEF = 16;

  // Conversion control modes
  typedef enum logic [1:0] {
    ASR_MODE_STARTSTOP = 2'b00,
    ASR_MODE_ONESHOT = 2'b01,
    ASR_MODE_SYNC = 2'b10,
    ASR_MODE_RSVD = 2'b11
  } asr_mode_t;

  // Conversion engine states
  typedef enum logic [0:0] {
    ASR_IDLE = 1'b0,
    ASR_RUN = 1'b1
  } asr_state_t;
endpackage
`default_nettype wire

// ===== hw/asr_flag.sv
`default_nettype none
module asr_flag (
  // Clock and clears
  input wire logic clk_sys,
  input wire logic clr_all,
  // Events
  input wire logic set,
  input wire logic clr,
  // Flag
  output logic q
);
  // Set wins over clear so a coincident event is never lost
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/asr_regs.sv
// Notes on behaviour
// - Frame CRC error blocks writes except status
// - Frame CRC check only when enabled; W1C
// - Map CRC mismatch sets flag when enabled
// - Map flag clears by W1C or disable
// - Fault flag read-only, cleared only by reset
// - Saturation flag refreshed at each conversion end
// - New-data bit is inverse of ready pin
// - New-data bit 1 new, 0 repeated
// - One-shot: new-data holds until next start
// - Reset only on code plus zero start/stop
// - Reset code field reads zero
// - One-shot start runs exactly one conversion
// - Start/stop mode converts until stopped
// - Start during conversion restarts it
// - Synchronized mode ignores start and stop
// - Start and stop together are ignored
// - Start and stop self-clear, read zero
// - Stop lets current conversion finish
`default_nettype none
module asr_regs #(
  parameter int CONV_CYCLES = asr_pkg::CONV_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register access from frame logic
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Frame and map checks
  input wire logic frame_crc_fail,
  input wire logic [7:0] map_crc_calc,
  // Converter side
  input wire asr_pkg::asr_mode_t conv_mode,
  input wire logic mod_sat,
  input wire logic adc_fault,
  input wire logic data_read,
  // Outputs
  output logic data_ready_n,
  output logic conv_active,
  output logic conv_done,
  output logic soft_reset
);
  import asr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (CONV_CYCLES < 2) begin : g_chk
    $error("CONV_CYCLES must be at least 2");
  end

  localparam int CW = $clog2(CONV_CYCLES);
  localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic clr_all;
  logic spi_err;
  logic reg_err;
  logic adc_err;
  logic wr_ok;
  logic cmd_wr;
  logic cmd_start;
  logic cmd_stop;
  logic go;
  logic halt;
  logic last;
  logic [7:0] cfg4_r;
  logic [7:0] map_crc_r;
  logic [7:0] status;
  logic [7:0] reg_rdata_r;
  logic soft_reset_r;
  logic data_ready_n_r;
  logic conv_done_r;
  logic sat_acc_r;
  logic sat_flag_r;
  logic oneshot_r;
  logic stop_pend_r;
  logic [CW-1:0] cnt_r;
  asr_state_t state_r;

  assign clr_all = !reset_n || soft_reset_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write qualification
  assign wr_ok = reg_wr && (!spi_err || reg_addr == ADDR_STATUS);
  assign cmd_wr = wr_ok && reg_addr == ADDR_CONTROL;
  // Both bits set decodes to neither command
  assign cmd_start = cmd_wr && reg_wdata[CMD_START] && !reg_wdata[CMD_STOP];
  assign cmd_stop = cmd_wr && reg_wdata[CMD_STOP] && !reg_wdata[CMD_START];
  assign go = cmd_start && conv_mode != ASR_MODE_SYNC;
  assign halt = cmd_stop && conv_mode != ASR_MODE_SYNC;
  assign last = state_r == ASR_RUN && cnt_r == CNT_LAST && !go;

  ////////////////////////////////////////////////////////////////////////////
  // Coded software reset
  // Takes effect one clock after the write, clearing every flag
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= cmd_wr && reg_wdata[7:2] == RESET_CODE && reg_wdata[1:0] == RESET_TAIL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and map CRC registers
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      cfg4_r <= CFG4_RESET_VAL;
    end else if (wr_ok && reg_addr == ADDR_FOURTH_CONFIG_REGISTER) begin
      cfg4_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      map_crc_r <= MAP_CRC_RESET_VAL;
    end else if (wr_ok && reg_addr == ADDR_MAP_CRC) begin
      map_crc_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky error flags
  asr_flag u_spi_err (
    .clk_sys(clk_sys),
    .clr_all(clr_all),
    .set(frame_crc_fail && cfg4_r[CFG4_FRAME_CHK]),
    .clr(wr_ok && reg_addr == ADDR_STATUS && reg_wdata[STAT_SPI_ERR]),
    .q(spi_err)
  );

  // Compared continuously, so a stale CRC keeps re-raising the flag
  asr_flag u_reg_err (
    .clk_sys(clk_sys),
    .clr_all(clr_all),
    .set(cfg4_r[CFG4_MAP_CHK] && map_crc_r != map_crc_calc),
    .clr(!cfg4_r[CFG4_MAP_CHK] || (wr_ok && reg_addr == ADDR_STATUS && reg_wdata[STAT_REG_ERR])),
    .q(reg_err)
  );

  // No software clear path on purpose
  asr_flag u_adc_err (
    .clk_sys(clk_sys),
    .clr_all(clr_all),
    .set(adc_fault),
    .clr(1'b0),
    .q(adc_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Conversion engine
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      state_r <= ASR_IDLE;
      cnt_r <= '0;
      oneshot_r <= 1'b0;
    end else begin
      case (state_r)
        ASR_IDLE: begin
          if (go) begin
            state_r <= ASR_RUN;
            cnt_r <= '0;
            oneshot_r <= conv_mode == ASR_MODE_ONESHOT;
          end
        end
        ASR_RUN: begin
          if (go) begin
            cnt_r <= '0;
            oneshot_r <= conv_mode == ASR_MODE_ONESHOT;
          end else if (last) begin
            cnt_r <= '0;
            if (oneshot_r || stop_pend_r) begin
              state_r <= ASR_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + CW'(1);
          end
        end
        default: begin
          state_r <= ASR_IDLE;
        end
      endcase
    end
  end

  // Stop only arms; the running conversion still completes
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      stop_pend_r <= 1'b0;
    end else if (go || (last && stop_pend_r)) begin
      stop_pend_r <= 1'b0;
    end else if (halt && state_r == ASR_RUN) begin
      stop_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      conv_done_r <= 1'b0;
    end else begin
      conv_done_r <= last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saturation tracking
  always_ff @(posedge clk_sys) begin
    if (clr_all || go || last) begin
      sat_acc_r <= 1'b0;
    end else if (state_r == ASR_RUN && mod_sat) begin
      sat_acc_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      sat_flag_r <= 1'b0;
    end else if (last) begin
      sat_flag_r <= sat_acc_r || mod_sat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-ready pin, active low
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      data_ready_n_r <= 1'b1;
    end else if (last) begin
      data_ready_n_r <= 1'b0;
    end else if (go) begin
      data_ready_n_r <= 1'b1;
    end else if (data_read && !oneshot_r) begin
      data_ready_n_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // Upper status bits belong elsewhere and read zero here
  always_comb begin
    status = READ_ZERO;
    status[STAT_SPI_ERR] = spi_err;
    status[STAT_REG_ERR] = reg_err;
    status[STAT_ADC_ERR] = adc_err;
    status[STAT_SAT] = sat_flag_r;
    status[STAT_NEW] = !data_ready_n_r;
  end

  // Reads are never gated by the frame error
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata_r <= READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: reg_rdata_r <= status;
        ADDR_CONTROL: reg_rdata_r <= {RESET_READ, 2'b00};
        ADDR_FOURTH_CONFIG_REGISTER: reg_rdata_r <= cfg4_r;
        ADDR_MAP_CRC: reg_rdata_r <= map_crc_r;
        default: reg_rdata_r <= READ_ZERO;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign data_ready_n = data_ready_n_r;
  assign conv_active = state_r;
  assign conv_done = conv_done_r;
  assign soft_reset = soft_reset_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_wr_block;
    spi_err && reg_wr && reg_addr == ADDR_FOURTH_CONFIG_REGISTER && !soft_reset_r |=> $stable(cfg4_r);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write passed while frame error set");

  property p_rd_live;
    spi_err && reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[STAT_SPI_ERR];
  endproperty
  a_rd_live: assert property (p_rd_live) else $error("read blocked by frame error");

  property p_spi_gate;
    !cfg4_r[CFG4_FRAME_CHK] && !spi_err && !soft_reset_r |=> !spi_err;
  endproperty
  a_spi_gate: assert property (p_spi_gate) else $error("frame error set while check disabled");

  property p_map_set;
    cfg4_r[CFG4_MAP_CHK] && map_crc_r != map_crc_calc && !soft_reset_r |=> reg_err;
  endproperty
  a_map_set: assert property (p_map_set) else $error("map mismatch not flagged");

  property p_map_off;
    !cfg4_r[CFG4_MAP_CHK] && !soft_reset_r |=> !reg_err;
  endproperty
  a_map_off: assert property (p_map_off) else $error("map flag held while check disabled");

  property p_fault_hold;
    adc_err && !soft_reset_r |=> adc_err;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag cleared without reset");

  property p_sat_upd;
    !last && !soft_reset_r |=> $stable(sat_flag_r);
  endproperty
  a_sat_upd: assert property (p_sat_upd) else $error("saturation flag changed mid conversion");

  property p_reset_code;
    cmd_wr && reg_wdata[7:2] == RESET_CODE && reg_wdata[1:0] != RESET_TAIL |=> !soft_reset_r;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("reset taken with start or stop set");

  property p_ctrl_read;
    reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata == READ_ZERO;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("command register read nonzero");

  property p_oneshot;
    state_r == ASR_RUN && oneshot_r && last |=> state_r == ASR_IDLE;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

  property p_restart;
    state_r == ASR_RUN && go && !soft_reset_r |=> cnt_r == '0 && state_r == ASR_RUN;
  endproperty
  a_restart: assert property (p_restart) else $error("start did not restart");

  property p_sync_idle;
    state_r == ASR_IDLE && cmd_start && conv_mode == ASR_MODE_SYNC && !soft_reset_r |=> state_r == ASR_IDLE;
  endproperty
  a_sync_idle: assert property (p_sync_idle) else $error("start acted in synchronized mode");

  property p_both;
    state_r == ASR_IDLE && cmd_wr && reg_wdata[1:0] == 2'b11 && !soft_reset_r |=> state_r == ASR_IDLE;
  endproperty
  a_both: assert property (p_both) else $error("start and stop together acted");

  property p_stop_finish;
    state_r == ASR_RUN && halt && !go && !last && !soft_reset_r |=> state_r == ASR_RUN;
  endproperty
  a_stop_finish: assert property (p_stop_finish) else $error("stop aborted conversion");

  c_oneshot: cover property (go && conv_mode == ASR_MODE_ONESHOT ##[1:40] conv_done);
  c_restart: cover property (state_r == ASR_RUN && go);
  c_stop: cover property (halt ##[1:40] state_r == ASR_IDLE);
  c_reset: cover property (soft_reset_r);
endmodule
`default_nettype wire

// ===== tb/asr_host_model.sv
`default_nettype none
module asr_host_model (
  // Clock
  input wire logic clk_sys,
  // Register bus
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import asr_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // Released lines show the inverse, so stale values never pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data stands until the next read, so one spare edge is safe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  ////////////////////////////////////////////////////////////
  // Command always preceded by a cleared command byte
  task automatic cmd(input logic [7:0] d);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, d);
  endtask
  // Code and zero start/stop in one write
  task automatic soft_rst;
    wr(ADDR_CONTROL, {RESET_CODE, RESET_TAIL});
  endtask
endmodule
`default_nettype wire

// ===== tb/adc_status_control_regs_bench.sv
`default_nettype none
module adc_status_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import asr_pkg::*;
  localparam int CC = 8;
  logic clk_sys, reset_n, reg_wr, reg_rd, frame_crc_fail, mod_sat, adc_fault, data_read;
  logic data_ready_n, conv_active, conv_done, soft_reset;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, map_crc_calc, v;
  asr_mode_t conv_mode;
  int fail_count = 0, checks_done = 0, resets = 0, k = 0;
  asr_regs #(.CONV_CYCLES(CC)) uut (.clk_sys, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .frame_crc_fail, .map_crc_calc, .conv_mode, .mod_sat, .adc_fault, .data_read, .data_ready_n,
    .conv_active, .conv_done, .soft_reset);
  asr_host_model h (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (soft_reset === 1'b1) resets++;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] a);
    checks_done++;
    if (a !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, a);
    end
  endtask
  task automatic st(input logic [7:0] e, input logic [7:0] m);
    h.rd(ADDR_STATUS, v);
    chk("status", e & m, v & m);
  endtask
  // One-cycle event pulse: bit 3 data read, 2 fault, 1 saturation, 0 frame CRC fail
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys) {data_read, adc_fault, mod_sat, frame_crc_fail} <= m;
    @(posedge clk_sys) {data_read, adc_fault, mod_sat, frame_crc_fail} <= 4'h0;
  endtask
  // Bounded wait; k reaching 100 means no completion
  task automatic wait_done;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (conv_done !== 1'b1 && k < 100);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    st(8'h00, 8'hFF);
    h.wr(ADDR_CONTROL, 8'hFC);
    h.rd(ADDR_CONTROL, v);
    chk("command", 8'h00, v);
  endtask
  task automatic t_oneshot;
    h.cmd(8'h02);
    wait_done;
    chk("length", 8'(CC), 8'(k));
    st(8'h01, 8'hFF);
    pulse(4'b1000);
    wait_done;
    chk("single", 8'h01, 8'(k == 100));
    chk("hold", 8'h00, {7'h0, data_ready_n});
    h.cmd(8'h02);
    pulse(4'b0010);
    #1 chk("renew", 8'h01, {7'h0, data_ready_n});
    wait_done;
    st(8'h03, 8'hFF);
    h.cmd(8'h02);
    wait_done;
    st(8'h01, 8'hFF);
  endtask
  task automatic t_startstop;
    @(posedge clk_sys) conv_mode <= ASR_MODE_STARTSTOP;
    h.cmd(8'h02);
    wait_done;
    wait_done;
    chk("repeat", 8'(CC), 8'(k));
    pulse(4'b1000);
    st(8'h00, 8'h01);
    wait_done;
    @(posedge clk_sys);
    h.cmd(8'h02);
    wait_done;
    chk("restart", 8'(CC), 8'(k));
    @(posedge clk_sys);
    h.cmd(8'h01);
    wait_done;
    chk("finish", 8'h01, 8'(k <= CC));
    chk("active", 8'h00, {7'h0, conv_active});
    wait_done;
    chk("stopped", 8'h01, 8'(k == 100));
    h.cmd(8'h03);
    repeat (3) @(posedge clk_sys);
    #1 chk("both", 8'h00, {7'h0, conv_active});
    @(posedge clk_sys) conv_mode <= ASR_MODE_SYNC;
    h.cmd(8'h02);
    repeat (3) @(posedge clk_sys);
    #1 chk("sync", 8'h00, {7'h0, conv_active});
    // Reserved mode code behaves as start/stop
    @(posedge clk_sys) conv_mode <= ASR_MODE_RSVD;
    h.cmd(8'h02);
    repeat (2) @(posedge clk_sys);
    #1 chk("rsvd", 8'h01, {7'h0, conv_active});
    h.cmd(8'h01);
    wait_done;
    chk("rsvd_stop", 8'h00, {7'h0, conv_active});
  endtask
  task automatic t_frame;
    @(posedge clk_sys) conv_mode <= ASR_MODE_ONESHOT;
    pulse(4'b0001);
    st(8'h00, 8'hFE);
    h.wr(ADDR_FOURTH_CONFIG_REGISTER, 8'h04);
    pulse(4'b0001);
    st(8'h10, 8'hFE);
    h.wr(ADDR_FOURTH_CONFIG_REGISTER, 8'h00);
    h.rd(ADDR_FOURTH_CONFIG_REGISTER, v);
    chk("fourth_config_register", 8'h04, v);
    h.cmd(8'h02);
    repeat (2) @(posedge clk_sys);
    #1 chk("blocked", 8'h00, {7'h0, conv_active});
    h.wr(ADDR_STATUS, 8'h10);
    st(8'h00, 8'hFE);
  endtask
  task automatic t_map;
    logic [7:0] crc;
    crc = 8'h5A;
    @(posedge clk_sys) map_crc_calc <= crc;
    h.wr(ADDR_FOURTH_CONFIG_REGISTER, 8'h06);
    st(8'h08, 8'hFE);
    h.wr(ADDR_MAP_CRC, crc);
    h.wr(ADDR_STATUS, 8'h08);
    st(8'h00, 8'hFE);
    h.wr(ADDR_MAP_CRC, 8'h00);
    st(8'h08, 8'hFE);
    h.wr(ADDR_FOURTH_CONFIG_REGISTER, 8'h04);
    st(8'h00, 8'hFE);
  endtask
  task automatic t_fault;
    int r0;
    pulse(4'b0100);
    h.wr(ADDR_STATUS, 8'hFF);
    st(8'h04, 8'hFE);
    r0 = resets;
    h.cmd(8'h5A);
    h.wr(ADDR_CONTROL, 8'h59);
    repeat (3) @(posedge clk_sys);
    chk("no_reset", 8'h00, 8'(resets - r0));
    h.soft_rst;
    repeat (3) @(posedge clk_sys);
    chk("soft_reset", 8'h01, 8'(resets - r0));
    st(8'h00, 8'hFE);
    h.rd(ADDR_FOURTH_CONFIG_REGISTER, v);
    chk("fourth_config_register", 8'h00, v);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    frame_crc_fail = 1'b0;
    mod_sat = 1'b0;
    adc_fault = 1'b0;
    data_read = 1'b0;
    map_crc_calc = 8'h00;
    conv_mode = ASR_MODE_ONESHOT;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_oneshot;
    t_startstop;
    t_frame;
    t_map;
    t_fault;
    tally_and_finish;
  end
  // Run needs a few hundred cycles at most
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
